// >>> logic/prcd_decoder.sv
// Command decoder and register bank behind the parallel data lines.
// Assumes cmd_write and read_strobe are single-cycle pulses synchronous to mclk.
module prcd_decoder #(
   parameter int unsigned stack_depth = prcd_pkg::stack_n
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmd_write,
   input wire logic [15:0] parallel_data_lines,
   input wire logic read_strobe,
   input wire logic [15:0] conv_result,
   input wire logic [7:0] last_pair_ids,
   input wire logic [7:0] checksum_value,
   output logic [15:0] read_data,
   output logic results_mode,
   output prcd_pkg::prcd_cfg_t config_out,
   output prcd_pkg::prcd_chan_t channel_out,
   output logic [35:0] range_out,
   output logic [stack_depth*9-1:0] stack_out
);
   logic [8:0] config_ff, nxt_config;
   logic [8:0] channel_ff, nxt_channel;
   logic [8:0] range_ff [4];
   logic [8:0] nxt_range [4];
   logic [8:0] stack_ff [stack_depth];
   logic [8:0] nxt_stack [stack_depth];
   logic [15:0] read_ff, nxt_read;
   logic results_ff, nxt_results;
   logic write_flag;
   logic [5:0] sel;
   logic [4:0] code;

   assign write_flag = parallel_data_lines[prcd_pkg::rw_bit];
   assign sel = parallel_data_lines[prcd_pkg::sel_hi:prcd_pkg::sel_lo];
   assign code = sel[4:0];

   function automatic logic [15:0] reg_word(input logic [5:0] s, input logic [8:0] v);
      reg_word = {1'b0, s, v};
   endfunction

   always_comb begin
      nxt_config = config_ff;
      nxt_channel = channel_ff;
      nxt_range = range_ff;
      nxt_stack = stack_ff;
      nxt_read = read_ff;
      nxt_results = results_ff;
      if (cmd_write) begin
         if (write_flag) begin
            if (sel[prcd_pkg::stack_bit]) begin
               if (32'(code) < stack_depth) nxt_stack[code] = parallel_data_lines[8:0];
            end else begin
               case (code)
                  prcd_pkg::code_config: nxt_config = parallel_data_lines[8:0];
                  prcd_pkg::code_channel: nxt_channel = parallel_data_lines[8:0];
                  prcd_pkg::code_range_a1: nxt_range[0] = parallel_data_lines[8:0];
                  prcd_pkg::code_range_a2: nxt_range[1] = parallel_data_lines[8:0];
                  prcd_pkg::code_range_b1: nxt_range[2] = parallel_data_lines[8:0];
                  prcd_pkg::code_range_b2: nxt_range[3] = parallel_data_lines[8:0];
                  default: ;
               endcase
            end
         end else begin
            nxt_results = 1'b0;
            if (sel[prcd_pkg::stack_bit]) begin
               nxt_read = (32'(code) < stack_depth) ? reg_word(sel, stack_ff[code]) : prcd_pkg::undefined_word;
            end else begin
               case (code)
                  prcd_pkg::code_results: nxt_results = 1'b1;
                  prcd_pkg::code_config: nxt_read = reg_word(sel, config_ff);
                  prcd_pkg::code_channel: nxt_read = reg_word(sel, channel_ff);
                  prcd_pkg::code_range_a1: nxt_read = reg_word(sel, range_ff[0]);
                  prcd_pkg::code_range_a2: nxt_read = reg_word(sel, range_ff[1]);
                  prcd_pkg::code_range_b1: nxt_read = reg_word(sel, range_ff[2]);
                  prcd_pkg::code_range_b2: nxt_read = reg_word(sel, range_ff[3]);
                  prcd_pkg::code_status: nxt_read = {last_pair_ids, checksum_value};
                  default: nxt_read = prcd_pkg::undefined_word;
               endcase
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         config_ff <= prcd_pkg::config_reset;
         channel_ff <= prcd_pkg::channel_reset;
         for (int i = 0; i < 4; i++) range_ff[i] <= prcd_pkg::range_reset;
         for (int i = 0; i < stack_depth; i++) begin
            if (i < prcd_pkg::stack_init_n) stack_ff[i] <= 9'({i[3:0], i[3:0]});
            else stack_ff[i] <= prcd_pkg::stack_reset;
         end
         read_ff <= prcd_pkg::undefined_word;
         results_ff <= 1'b0;
      end else begin
         config_ff <= nxt_config;
         channel_ff <= nxt_channel;
         range_ff <= nxt_range;
         stack_ff <= nxt_stack;
         read_ff <= nxt_read;
         results_ff <= nxt_results;
      end
   end

   // Read cycle returns armed word or results
   assign read_data = results_ff ? conv_result : read_ff;
   assign results_mode = results_ff;

   always_comb begin
      config_out.self_detect = config_ff[prcd_pkg::cfg_self_det];
      config_out.burst_enable = config_ff[prcd_pkg::cfg_burst_en];
      config_out.sequencer_enable = config_ff[prcd_pkg::cfg_seq_en];
      config_out.oversampling = config_ff[prcd_pkg::cfg_os_hi:prcd_pkg::cfg_os_lo];
      config_out.status_word_enable = config_ff[prcd_pkg::cfg_status_en] | config_ff[prcd_pkg::cfg_crc_en];
      config_out.checksum_enable = config_ff[prcd_pkg::cfg_crc_en] | config_ff[prcd_pkg::cfg_status_en];
      config_out.checksum_active = config_out.checksum_enable;
   end

   assign channel_out = channel_ff[7:0];
   assign range_out = {range_ff[3][8:0], range_ff[2][8:0], range_ff[1][8:0], range_ff[0][8:0]};

   genvar g;
   generate
      for (g = 0; g < stack_depth; g++) begin : g_stack
         assign stack_out[g*9 +: 9] = stack_ff[g];
      end
   endgenerate

   a_cfg_write: assert property (@(posedge mclk) disable iff (rst)
      cmd_write && parallel_data_lines[15:9] == 7'h42 |=> config_ff == $past(parallel_data_lines[8:0]))
      else $error("config write lost");
   a_cfg_read: assert property (@(posedge mclk) disable iff (rst)
      cmd_write && parallel_data_lines[15:9] == 7'h02 |=> read_data == {7'h02, config_ff})
      else $error("config read wrong");
   a_res_mode: assert property (@(posedge mclk) disable iff (rst)
      cmd_write && parallel_data_lines[15:9] == 7'h00 |=> results_mode && read_data == conv_result)
      else $error("results mode missing");
   a_rsv_write: assert property (@(posedge mclk) disable iff (rst)
      cmd_write && parallel_data_lines[15:9] == 7'h41 |=> $stable(config_ff) && $stable(channel_ff))
      else $error("reserved write changed state");
   a_crc_join: assert property (@(posedge mclk) disable iff (rst)
      config_out.checksum_enable == (config_ff[0] | config_ff[1]))
      else $error("checksum enable wrong");
   a_stat_read: assert property (@(posedge mclk) disable iff (rst)
      cmd_write && parallel_data_lines[15:9] == 7'h08 |=> read_data == {$past(last_pair_ids), $past(checksum_value)})
      else $error("status word wrong");
endmodule

// >>> shared/prcd_pkg.sv
// Constants and carrier types for the parallel register command decoder.
// Assumes one 50 MHz clock and command words already latched by the pin logic.
package prcd_pkg;
   localparam int unsigned word_w = 16;
   localparam int unsigned data_w = 9;
   localparam int unsigned rw_bit = 15;
   localparam int unsigned sel_hi = 14;
   localparam int unsigned sel_lo = 9;
   localparam int unsigned stack_bit = 5;
   localparam int unsigned stack_n = 32;
   localparam int unsigned stack_init_n = 8;
   localparam logic [4:0] code_results = 5'h00;
   localparam logic [4:0] code_config = 5'h02;
   localparam logic [4:0] code_channel = 5'h03;
   localparam logic [4:0] code_range_a1 = 5'h04;
   localparam logic [4:0] code_range_a2 = 5'h05;
   localparam logic [4:0] code_range_b1 = 5'h06;
   localparam logic [4:0] code_range_b2 = 5'h07;
   localparam logic [4:0] code_status = 5'h08;
   localparam logic [8:0] config_reset = 9'h000;
   localparam logic [8:0] channel_reset = 9'h000;
   localparam logic [8:0] range_reset = 9'h0ff;
   localparam logic [8:0] stack_reset = 9'h000;
   localparam logic [15:0] undefined_word = 16'h0000;
   // Configuration field positions
   localparam int unsigned cfg_crc_en = 0;
   localparam int unsigned cfg_status_en = 1;
   localparam int unsigned cfg_os_lo = 2;
   localparam int unsigned cfg_os_hi = 4;
   localparam int unsigned cfg_seq_en = 5;
   localparam int unsigned cfg_burst_en = 6;
   localparam int unsigned cfg_self_det = 7;

   typedef struct packed {
      logic self_detect;
      logic burst_enable;
      logic sequencer_enable;
      logic [2:0] oversampling;
      logic status_word_enable;
      logic checksum_enable;
      logic checksum_active;
   } prcd_cfg_t;

   typedef struct packed {
      logic [3:0] converter_b_channel_select;
      logic [3:0] converter_a_channel_select;
   } prcd_chan_t;
endpackage

// >>> test/prcd_host.sv
// Host model that issues command words and read cycles on the parallel lines.
// Assumes the bench calls its tasks from one process, one call at a time.
module prcd_host (
   input wire logic mclk,
   output logic cmd_write,
   output logic [15:0] parallel_data_lines,
   output logic read_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_write = 1'b0;
      parallel_data_lines = 16'h0000;
      read_strobe = 1'b0;
   end
   task automatic send(input logic [15:0] w);
      @(posedge mclk);
      cmd_write <= 1'b1;
      parallel_data_lines <= w;
      @(posedge mclk);
      cmd_write <= 1'b0;
      parallel_data_lines <= ~w;
   endtask
   task automatic fetch();
      @(posedge mclk);
      read_strobe <= 1'b1;
      @(posedge mclk);
      read_strobe <= 1'b0;
   endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench for the command decoder driven by the host model.
// Assumes the package and host model are compiled first.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
      $display("unexpected %s exp %h got %h", n, e, g); end end
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cmd_write, read_strobe, results_mode;
   logic [15:0] parallel_data_lines, read_data;
   logic [15:0] conv_result = 16'h1234;
   logic [7:0] last_pair_ids = 8'h5a;
   logic [7:0] checksum_value = 8'hc3;
   logic [35:0] range_out;
   logic [287:0] stack_out;
   logic [340:0] save;
   logic [8:0] v;
   prcd_pkg::prcd_cfg_t config_out;
   prcd_pkg::prcd_chan_t channel_out;
   int bad_count = 0;
   int tests_run = 0;
   always #10 mclk = ~mclk;
   prcd_host i_prcd_host (.mclk(mclk), .cmd_write(cmd_write), .parallel_data_lines(parallel_data_lines),
      .read_strobe(read_strobe));
   prcd_decoder i_prcd_decoder (.mclk(mclk), .rst(rst), .cmd_write(cmd_write),
      .parallel_data_lines(parallel_data_lines), .read_strobe(read_strobe), .conv_result(conv_result),
      .last_pair_ids(last_pair_ids), .checksum_value(checksum_value), .read_data(read_data),
      .results_mode(results_mode), .config_out(config_out), .channel_out(channel_out),
      .range_out(range_out), .stack_out(stack_out));
   task automatic summarize();
      if (bad_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [15:0] w);
      i_prcd_host.send(w);
      @(negedge mclk);
   endtask
   task automatic rd(input logic [5:0] s);
      wr({1'b0, s, 9'h000});
      i_prcd_host.fetch();
      @(negedge mclk);
   endtask
   initial begin
      repeat (5000) @(posedge mclk);
      bad_count++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      `CHK("cfg_rst", 9'h000, config_out)
      `CHK("stk_rst", 9'h033, stack_out[35:27])
      for (int i = 0; i < 4; i++) begin
         v = {2'h1, i[1:0], 3'(i + 3), i[1:0]};
         wr({1'b1, 6'h02, v});
         `CHK("active", |v[1:0], config_out.checksum_active)
         `CHK("os", v[4:2], config_out.oversampling)
         `CHK("seq", v[5], config_out.sequencer_enable)
         rd(6'h02);
         `CHK("cfg_rd", {7'h02, v}, read_data)
      end
      wr(16'h86a5);
      `CHK("chan", 8'ha5, channel_out)
      for (int k = 0; k < 4; k++) begin
         wr({1'b1, 6'(4 + k), 9'(k * 16 + 1)});
         `CHK("range", 9'(k * 16 + 1), range_out[k * 9 +: 9])
      end
      wr({1'b1, 6'h3f, 9'h1e7});
      `CHK("stack", 9'h1e7, stack_out[279 +: 9])
      save = {config_out, channel_out, range_out, stack_out};
      wr({1'b1, 6'h01, 9'h1ff});
      wr({1'b1, 6'h08, 9'h1ff});
      wr({1'b1, 6'h1f, 9'h1ff});
      `CHK("rsv_wr", save, {config_out, channel_out, range_out, stack_out})
      rd(6'h01);
      `CHK("rsv_rd", 16'h0000, read_data)
      rd(6'h08);
      `CHK("status", 16'h5ac3, read_data)
      rd(6'h00);
      `CHK("mode", 1'b1, results_mode)
      `CHK("result", 16'h1234, read_data)
      @(posedge mclk);
      conv_result <= 16'hbeef;
      @(negedge mclk);
      `CHK("result2", 16'hbeef, read_data)
      rd(6'h03);
      `CHK("mode_off", 1'b0, results_mode)
      `CHK("chan_rd", {7'h03, 9'h0a5}, read_data)
      summarize();
   end
endmodule
